// file: hw/shutter_drive.sv
// Blind and shutter drive control with APB registers
`timescale 1ns/10ps

// What this block does
// - Blind mode has slats, shutter mode none
// - UP or DOWN energises that contact
// - Travel runs until STOP or timeout
// - Contact held for travel plus overflow
// - Position estimated from travel time
// - Down closes slats, up opens them
// - STEP energises for slat duration only
// - Reversal waits with both contacts off
// - Up and down contacts never both on
// - Safety start runs configured action
// - Safety release moves to set position
// - Scene telegram is one byte, values local
// - Scene number sent as number minus one
// - Only matching scene numbers are acted on
// - Recall moves to stored value, store saves
// - Limit status 00 between,01 low,10 up,11 undefined
module shutter_drive
  import shutter_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES,
  parameter int unsigned NUM_SCENES = 4
) (
  input  wire logic                      I_CORE_CLK,
  input  wire logic                      I_SYS_RST,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [shutter_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [shutter_pkg::DATA_W-1:0] I_PWDATA,
  output logic      [shutter_pkg::DATA_W-1:0] O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire logic                      I_END_UP,
  input  wire logic                      I_END_DOWN,
  output logic                           O_CONTACT_UP,
  output logic                           O_CONTACT_DOWN,
  output logic      [1:0]                O_LIMIT_STATUS,
  output logic                           O_IRQ
);
  import shutter_pkg::*;

  // Slot index from a slot register address
  function automatic int unsigned slot_of(input logic [ADDR_W-1:0] a);
    slot_of = int'((a - OFF_SLOT_BASE) >> 2);
  endfunction

  // Configuration and state registers
  logic                  blind_reg;
  logic [TIME_W-1:0]     travel_reg;
  logic [TIME_W-1:0]     overflow_reg;
  logic [TIME_W-1:0]     slat_reg;
  logic [TIME_W-1:0]     reverse_reg;
  logic [1:0]            safe_act_reg;
  logic [POS_W-1:0]      safe_pos_reg;
  logic                  safe_reg;
  logic                  safe_prev_reg;
  logic [IRQ_W-1:0]      irq_stat_reg;
  logic [IRQ_W-1:0]      irq_mask_reg;
  logic [NUM_W-1:0]      slot_num_reg [NUM_SCENES];
  logic                  slot_en_reg  [NUM_SCENES];
  logic [POS_W-1:0]      slot_pos_reg [NUM_SCENES];
  motor_state_type       state_reg, state_next;
  op_type                op_reg, op_next;
  logic                  dir_reg, dir_next;
  logic                  last_dir_reg, last_dir_next;
  logic [CNT_W-1:0]      cnt_reg, cnt_next;
  logic [CNT_W-1:0]      limit_reg, limit_next;
  logic [POS_W-1:0]      goal_reg, goal_next;
  logic [POS_W-1:0]      pos_reg, pos_next;
  logic [CNT_W-1:0]      acc_reg, acc_next;
  logic                  known_reg, known_next;
  logic                  slat_reg_closed, slat_next;
  logic                  pend_reg;
  op_type                pend_op_reg;
  logic                  pend_dir_reg;
  logic [POS_W-1:0]      pend_goal_reg;
  logic                  ev_done, ev_limit;
  logic [DATA_W-1:0]     rd_next;
  logic                  err_next;
  logic                  tick;

  tick_gen #(.CYCLES(TICK_CYC)) u_tick (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_SYS_RST),
    .o_tick (tick)
  );

  // APB phase and address decode
  wire setup    = I_PSEL & ~I_PENABLE;
  wire wr_en    = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire slot_hit = (I_PADDR >= OFF_SLOT_BASE) && (I_PADDR[1:0] == 2'h0) &&
                  (slot_of(I_PADDR) < NUM_SCENES);
  wire [2:0] cmd_code  = I_PWDATA[2:0];
  wire wr_cmd   = wr_en & (I_PADDR == OFF_CMD) & ~safe_reg;
  wire wr_goto  = wr_en & (I_PADDR == OFF_GOTO) & ~safe_reg;
  wire wr_scene = wr_en & (I_PADDR == OFF_SCENE);

  // Scene telegram: store flag and bus-coded number
  wire                 scene_store = I_PWDATA[SCENE_STORE_BIT];
  wire [NUM_W-1:0]     scene_num   = I_PWDATA[NUM_W-1:0];
  logic [NUM_SCENES-1:0] scene_hit;
  logic [POS_W-1:0]      recall_pos;

  // Slot match per scene slot
  genvar g;
  generate
    for (g = 0; g < NUM_SCENES; g++) begin : g_match
      assign scene_hit[g] = slot_en_reg[g] && (slot_num_reg[g] == scene_num);
    end
  endgenerate

  // First matching slot supplies the recalled position
  always_comb begin
    recall_pos = POS_TOP;
    for (int i = NUM_SCENES - 1; i >= 0; i--) begin
      if (scene_hit[i]) begin
        recall_pos = slot_pos_reg[i];
      end
    end
  end

  wire do_recall = wr_scene & ~scene_store & (|scene_hit) & ~safe_reg;
  wire do_store  = wr_scene & scene_store & (|scene_hit);
  wire safe_rise = safe_reg & ~safe_prev_reg;
  wire safe_fall = ~safe_reg & safe_prev_reg;

  // Request selection, safety first
  wire   req_safe  = safe_rise & (safe_act_reg != SAFE_KEEP);
  wire   step_ok   = blind_reg & ((cmd_code == CMD_STEP_UP) | (cmd_code == CMD_STEP_DOWN));
  wire   cmd_ok    = (cmd_code == CMD_UP) | (cmd_code == CMD_DOWN) |
                     (cmd_code == CMD_STOP) | step_ok;
  wire   req_valid = req_safe | safe_fall | do_recall | (wr_cmd & cmd_ok) | wr_goto;
  op_type req_op;
  logic   req_dir;
  logic [POS_W-1:0] req_goal;

  // Request operation, direction and goal
  always_comb begin
    req_op   = OP_STOP;
    req_dir  = 1'b0;
    req_goal = POS_TOP;
    if (req_safe) begin
      req_op  = (safe_act_reg == SAFE_STOP) ? OP_STOP : OP_MOVE;
      req_dir = (safe_act_reg == SAFE_DOWN);
    end else if (safe_fall) begin
      req_op   = OP_GOTO;
      req_goal = safe_pos_reg;
    end else if (do_recall) begin
      req_op   = OP_GOTO;
      req_goal = recall_pos;
    end else if (wr_goto) begin
      req_op   = OP_GOTO;
      req_goal = I_PWDATA[POS_W-1:0];
    end else begin
      req_op  = (cmd_code == CMD_STOP) ? OP_STOP :
                (step_ok ? OP_STEP : OP_MOVE);
      req_dir = (cmd_code == CMD_DOWN) | (cmd_code == CMD_STEP_DOWN);
    end
  end

  // Resolution of the pending request at a tick
  wire goal_end   = (pend_goal_reg == POS_TOP) | (pend_goal_reg == POS_BOTTOM);
  wire goto_dir   = (pend_goal_reg > pos_reg);
  wire start_dir  = (pend_op_reg == OP_GOTO) ? (goal_end ? pend_goal_reg[0] : goto_dir)
                                             : pend_dir_reg;
  wire goto_here  = (pend_op_reg == OP_GOTO) & ~goal_end & (pend_goal_reg == pos_reg);
  wire [CNT_W-1:0] full_lim = {1'b0, travel_reg} + {1'b0, overflow_reg};
  wire [CNT_W-1:0] start_lim = (pend_op_reg == OP_STEP) ? {1'b0, slat_reg} : full_lim;
  wire [CNT_W-1:0] cnt_inc  = cnt_reg + CNT_W'(1);
  wire [CNT_W-1:0] acc_sum  = acc_reg + CNT_W'(POS_BOTTOM);
  wire             pos_step = (acc_sum >= {1'b0, travel_reg});
  wire             end_hit  = dir_reg ? I_END_DOWN : I_END_UP;
  wire [POS_W-1:0] end_pos  = dir_reg ? POS_BOTTOM : POS_TOP;

  // Drive state machine, advanced on the timing tick
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    dir_next      = dir_reg;
    last_dir_next = last_dir_reg;
    cnt_next      = cnt_reg;
    limit_next    = limit_reg;
    goal_next     = goal_reg;
    pos_next      = pos_reg;
    acc_next      = acc_reg;
    known_next    = known_reg;
    slat_next     = slat_reg_closed;
    ev_done       = 1'b0;
    ev_limit      = 1'b0;
    if (tick && pend_reg) begin
      cnt_next = '0;
      if (pend_op_reg == OP_STOP || goto_here) begin
        state_next = ST_IDLE;
      end else begin
        op_next    = (pend_op_reg == OP_GOTO && goal_end) ? OP_MOVE : pend_op_reg;
        dir_next   = start_dir;
        limit_next = start_lim;
        goal_next  = pend_goal_reg;
        if (start_dir != last_dir_reg) begin
          state_next = ST_REVERSE;
        end else begin
          state_next = ST_RUN;
          slat_next  = blind_reg & start_dir;
        end
      end
    end else if (tick) begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_REVERSE: begin
          cnt_next = cnt_inc;
          if (cnt_inc >= {1'b0, reverse_reg}) begin
            state_next    = ST_RUN;
            cnt_next      = '0;
            last_dir_next = dir_reg;
            slat_next     = blind_reg & dir_reg;
          end
        end
        ST_RUN: begin
          cnt_next = cnt_inc;
          acc_next = pos_step ? acc_sum - {1'b0, travel_reg} : acc_sum;
          if (pos_step && pos_reg != end_pos) begin
            pos_next = dir_reg ? pos_reg + POS_W'(1) : pos_reg - POS_W'(1);
          end
          if (end_hit) begin
            pos_next   = end_pos;
            known_next = 1'b1;
            ev_limit   = ~known_reg | (pos_reg != end_pos);
          end
          if (cnt_inc >= limit_reg) begin
            state_next = ST_IDLE;
            ev_done    = 1'b1;
            if (op_reg == OP_MOVE) begin
              pos_next   = end_pos;
              known_next = 1'b1;
            end
          end else if (op_reg == OP_GOTO && pos_next == goal_reg) begin
            state_next = ST_IDLE;
            ev_done    = 1'b1;
          end
        end
      endcase
    end
  end

  // Contacts follow run state and one direction bit only
  wire up_next   = (state_next == ST_RUN) & ~dir_next;
  wire down_next = (state_next == ST_RUN) & dir_next;
  wire [1:0] lim_next = ~known_next ? LIM_UNDEF :
                        (pos_next == POS_BOTTOM) ? LIM_LOWER :
                        (pos_next == POS_TOP) ? LIM_UPPER : LIM_BETWEEN;

  // Interrupt status: hardware set wins over write-one clear
  wire [IRQ_W-1:0] events = {safe_rise | safe_fall, do_store, ev_limit, ev_done};
  wire [IRQ_W-1:0] w1c    = (wr_en && I_PADDR == OFF_IRQ_STAT) ? I_PWDATA[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~w1c) | events;
  wire [IRQ_W-1:0] irq_mask_next = (wr_en && I_PADDR == OFF_IRQ_MASK) ?
                                   I_PWDATA[IRQ_W-1:0] : irq_mask_reg;

  // Read data mux
  always_comb begin
    rd_next  = '0;
    err_next = 1'b0;
    if (slot_hit) begin
      rd_next[NUM_W-1:0]                 = slot_num_reg[slot_of(I_PADDR)];
      rd_next[SLOT_EN_BIT]               = slot_en_reg[slot_of(I_PADDR)];
      rd_next[SLOT_POS_LSB +: POS_W]     = slot_pos_reg[slot_of(I_PADDR)];
    end else begin
      unique case (I_PADDR)
        OFF_CTRL:     rd_next[CTRL_BLIND_BIT] = blind_reg;
        OFF_CMD:      rd_next = '0;
        OFF_SCENE:    rd_next = '0;
        OFF_TRAVEL:   rd_next[TIME_W-1:0] = travel_reg;
        OFF_OVERFLOW: rd_next[TIME_W-1:0] = overflow_reg;
        OFF_SLAT:     rd_next[TIME_W-1:0] = slat_reg;
        OFF_REVERSE:  rd_next[TIME_W-1:0] = reverse_reg;
        OFF_SAFE_CFG: rd_next = {16'h0000, safe_pos_reg, 6'h00, safe_act_reg};
        OFF_SAFE:     rd_next[0] = safe_reg;
        OFF_GOTO:     rd_next[POS_W-1:0] = goal_reg;
        OFF_STATUS: begin
          rd_next[POS_W-1:0]          = pos_reg;
          rd_next[ST_LIM_LSB +: 2]    = O_LIMIT_STATUS;
          rd_next[ST_UP_BIT]          = O_CONTACT_UP;
          rd_next[ST_DOWN_BIT]        = O_CONTACT_DOWN;
          rd_next[ST_SAFE_BIT]        = safe_reg;
          rd_next[ST_SLAT_BIT]        = slat_reg_closed;
        end
        OFF_IRQ_STAT: rd_next[IRQ_W-1:0] = irq_stat_reg;
        OFF_IRQ_MASK: rd_next[IRQ_W-1:0] = irq_mask_reg;
        default:      err_next = 1'b1;
      endcase
    end
  end

  // APB answer: ready in the access cycle after every setup
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= '0;
    end else begin
      O_PREADY  <= setup;
      O_PSLVERR <= setup & err_next;
      O_PRDATA  <= (setup & ~I_PWRITE) ? rd_next : '0;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      blind_reg    <= 1'b1;
      travel_reg   <= TRAVEL_RST;
      overflow_reg <= OVERFLOW_RST;
      slat_reg     <= SLAT_RST;
      reverse_reg  <= REVERSE_RST;
      safe_act_reg <= SAFE_ACT_RST;
      safe_pos_reg <= POS_TOP;
      safe_reg     <= 1'b0;
    end else if (wr_en) begin
      unique case (I_PADDR)
        OFF_CTRL:     blind_reg    <= I_PWDATA[CTRL_BLIND_BIT];
        OFF_TRAVEL:   travel_reg   <= I_PWDATA[TIME_W-1:0];
        OFF_OVERFLOW: overflow_reg <= I_PWDATA[TIME_W-1:0];
        OFF_SLAT:     slat_reg     <= I_PWDATA[TIME_W-1:0];
        OFF_REVERSE:  reverse_reg  <= I_PWDATA[TIME_W-1:0];
        OFF_SAFE_CFG: begin
          safe_act_reg <= I_PWDATA[SAFE_ACT_LSB +: 2];
          safe_pos_reg <= I_PWDATA[SAFE_POS_LSB +: POS_W];
        end
        OFF_SAFE:     safe_reg     <= I_PWDATA[0];
        default: begin
        end
      endcase
    end
  end

  // Scene slots: software setup, hardware store of current position
  generate
    for (g = 0; g < NUM_SCENES; g++) begin : g_slot
      wire wr_slot = wr_en & slot_hit & (slot_of(I_PADDR) == g);
      always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
          slot_num_reg[g] <= '0;
          slot_en_reg[g]  <= 1'b0;
          slot_pos_reg[g] <= POS_TOP;
        end else if (do_store && scene_hit[g]) begin
          slot_pos_reg[g] <= pos_reg;
        end else if (wr_slot) begin
          slot_num_reg[g] <= I_PWDATA[NUM_W-1:0];
          slot_en_reg[g]  <= I_PWDATA[SLOT_EN_BIT];
          slot_pos_reg[g] <= I_PWDATA[SLOT_POS_LSB +: POS_W];
        end
      end
    end
  endgenerate

  // Pending request, newest wins, consumed on the tick
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pend_reg      <= 1'b0;
      pend_op_reg   <= OP_STOP;
      pend_dir_reg  <= 1'b0;
      pend_goal_reg <= POS_TOP;
      safe_prev_reg <= 1'b0;
    end else begin
      safe_prev_reg <= safe_reg;
      if (req_valid) begin
        pend_reg      <= 1'b1;
        pend_op_reg   <= req_op;
        pend_dir_reg  <= req_dir;
        pend_goal_reg <= req_goal;
      end else if (tick) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Drive state, position and outputs
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_reg       <= ST_IDLE;
      op_reg          <= OP_STOP;
      dir_reg         <= 1'b0;
      last_dir_reg    <= 1'b0;
      cnt_reg         <= '0;
      limit_reg       <= '0;
      goal_reg        <= POS_TOP;
      pos_reg         <= POS_TOP;
      acc_reg         <= '0;
      known_reg       <= 1'b0;
      slat_reg_closed <= 1'b0;
      O_CONTACT_UP    <= 1'b0;
      O_CONTACT_DOWN  <= 1'b0;
      O_LIMIT_STATUS  <= LIM_UNDEF;
    end else begin
      state_reg       <= state_next;
      op_reg          <= op_next;
      dir_reg         <= dir_next;
      last_dir_reg    <= (state_next == ST_RUN) ? dir_next : last_dir_next;
      cnt_reg         <= cnt_next;
      limit_reg       <= limit_next;
      goal_reg        <= goal_next;
      pos_reg         <= pos_next;
      acc_reg         <= acc_next;
      known_reg       <= known_next;
      slat_reg_closed <= slat_next;
      O_CONTACT_UP    <= up_next;
      O_CONTACT_DOWN  <= down_next;
      O_LIMIT_STATUS  <= lim_next;
    end
  end

  // Interrupt registers and masked output
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      O_IRQ        <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      O_IRQ        <= |(irq_stat_next & irq_mask_next);
    end
  end
endmodule

// file: hw/shutter_pkg.sv
// Constants, register map and types of the blind and shutter drive control
package shutter_pkg;
  // Register bus geometry and field widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIME_W = 16;
  localparam int CNT_W  = 17;
  localparam int POS_W  = 8;
  localparam int NUM_W  = 6;
  localparam int IRQ_W  = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD       = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TRAVEL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OVERFLOW  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SLAT      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_REVERSE   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SAFE_CFG  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SAFE      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_SCENE     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_GOTO      = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_SLOT_BASE = 8'h40;

  // Command codes written to the command register
  localparam logic [2:0] CMD_UP        = 3'h1;
  localparam logic [2:0] CMD_DOWN      = 3'h2;
  localparam logic [2:0] CMD_STOP      = 3'h3;
  localparam logic [2:0] CMD_STEP_UP   = 3'h4;
  localparam logic [2:0] CMD_STEP_DOWN = 3'h5;

  // Safety actions
  localparam logic [1:0] SAFE_UP   = 2'h0;
  localparam logic [1:0] SAFE_DOWN = 2'h1;
  localparam logic [1:0] SAFE_STOP = 2'h2;
  localparam logic [1:0] SAFE_KEEP = 2'h3;

  // Limit status codes
  localparam logic [1:0] LIM_BETWEEN = 2'h0;
  localparam logic [1:0] LIM_LOWER   = 2'h1;
  localparam logic [1:0] LIM_UPPER   = 2'h2;
  localparam logic [1:0] LIM_UNDEF   = 2'h3;

  // Field positions
  localparam int CTRL_BLIND_BIT  = 0;
  localparam int SAFE_ACT_LSB    = 0;
  localparam int SAFE_POS_LSB    = 8;
  localparam int SCENE_STORE_BIT = 7;
  localparam int SLOT_EN_BIT     = 7;
  localparam int SLOT_POS_LSB    = 8;
  localparam int ST_LIM_LSB      = 8;
  localparam int ST_UP_BIT       = 10;
  localparam int ST_DOWN_BIT     = 11;
  localparam int ST_SAFE_BIT     = 12;
  localparam int ST_SLAT_BIT     = 13;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_LIMIT_BIT   = 1;
  localparam int IRQ_STORE_BIT   = 2;
  localparam int IRQ_SAFE_BIT    = 3;

  // Positions: 00 is fully up, FF fully down
  localparam logic [POS_W-1:0] POS_TOP    = 8'h00;
  localparam logic [POS_W-1:0] POS_BOTTOM = 8'hFF;

  // Reset values, times in ticks
  localparam logic [TIME_W-1:0] TRAVEL_RST   = 16'h7530;
  localparam logic [TIME_W-1:0] OVERFLOW_RST = 16'h07D0;
  localparam logic [TIME_W-1:0] SLAT_RST     = 16'h0064;
  localparam logic [TIME_W-1:0] REVERSE_RST  = 16'h01F4;
  localparam logic [1:0]        SAFE_ACT_RST = 2'h2;

  // Timing tick
  localparam int CLK_FREQ_HZ = 125000000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000000) * TICK_US;

  typedef enum logic [1:0] {ST_IDLE, ST_REVERSE, ST_RUN} motor_state_type;
  typedef enum logic [1:0] {OP_STOP, OP_MOVE, OP_STEP, OP_GOTO} op_type;
endpackage

// file: hw/tick_gen.sv
// Timing tick generator for the drive control
`timescale 1ns/10ps
module tick_gen #(
  parameter int unsigned CYCLES = 125000
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_reg;
  wire          wrap = (cnt_reg == LAST);

  // Free running divider with one-cycle tick
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
      o_tick  <= wrap;
    end
  end
endmodule

// file: verif/shutter_drive_asserts.sv
// Port checker for the drive control
`timescale 1ns/10ps
module shutter_drive_asserts
  import shutter_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic                              I_CORE_CLK,
  input wire logic                              I_SYS_RST,
  input wire logic                              I_PSEL,
  input wire logic                              I_PENABLE,
  input wire logic                              I_PWRITE,
  input wire logic [shutter_pkg::ADDR_W-1:0]    I_PADDR,
  input wire logic [shutter_pkg::DATA_W-1:0]    I_PWDATA,
  input wire logic [shutter_pkg::DATA_W-1:0]    O_PRDATA,
  input wire logic                              O_PREADY,
  input wire logic                              O_PSLVERR,
  input wire logic                              I_END_UP,
  input wire logic                              I_END_DOWN,
  input wire logic                              O_CONTACT_UP,
  input wire logic                              O_CONTACT_DOWN,
  input wire logic [1:0]                        O_LIMIT_STATUS,
  input wire logic                              O_IRQ
);
  localparam int LIM_WAIT = 2 * TICK_CYC + 2;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Bus phase and contact sequences, then port properties
  sequence s_setup; I_PSEL && !I_PENABLE; endsequence
  sequence s_low_down; !O_CONTACT_DOWN [*3]; endsequence
  sequence s_low_up; !O_CONTACT_UP [*3]; endsequence
  property p_excl; !(O_CONTACT_UP && O_CONTACT_DOWN); endproperty
  a_excl: assert property (p_excl) else $error("both contacts on");
  property p_rev_up; $fell(O_CONTACT_UP) |-> s_low_down; endproperty
  a_rev_up: assert property (p_rev_up) else $error("no pause after up");
  property p_rev_dn; $fell(O_CONTACT_DOWN) |-> s_low_up; endproperty
  a_rev_dn: assert property (p_rev_dn) else $error("no pause after down");
  property p_ready; s_setup |=> O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_cause; O_PREADY |-> $past(I_PSEL && !I_PENABLE); endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err; O_PSLVERR |-> O_PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd; !O_PREADY |-> O_PRDATA == '0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside access");
  property p_lim;
    I_END_DOWN && O_CONTACT_DOWN |-> ##[1:LIM_WAIT] O_LIMIT_STATUS == LIM_LOWER;
  endproperty
  a_lim: assert property (p_lim) else $error("lower limit not shown");
endmodule

bind shutter_drive shutter_drive_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_END_UP(I_END_UP), .I_END_DOWN(I_END_DOWN),
  .O_CONTACT_UP(O_CONTACT_UP), .O_CONTACT_DOWN(O_CONTACT_DOWN),
  .O_LIMIT_STATUS(O_LIMIT_STATUS), .O_IRQ(O_IRQ));

// file: verif/motor_model.sv
// Drive motor with end switches
`timescale 1ns/10ps
module motor_model #(
  parameter int RUN = 600
) (
  input  wire logic i_clk,
  input  wire logic i_up,
  input  wire logic i_down,
  output logic      o_end_up,
  output logic      o_end_down
);
  int pos_reg = 0;
  // Motor stops itself at either end switch
  always_ff @(posedge i_clk) begin
    if (i_down && pos_reg < RUN) pos_reg <= pos_reg + 1;
    if (i_up && pos_reg > 0) pos_reg <= pos_reg - 1;
  end
  assign o_end_up   = (pos_reg == 0);
  assign o_end_down = (pos_reg == RUN);
endmodule

// file: verif/shutter_drive_test.sv
// Bench for the drive control
`timescale 1ns/10ps
module shutter_drive_test;
  import shutter_pkg::*;
  localparam int TK = 4;
  logic              clk = 0;
  logic              rst = 1;
  logic              psel = 0;
  logic              pen = 0;
  logic              pwr = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready, pslverr, eu, ed, cu, cd, irq;
  logic [1:0]        lim;
  int                fails = 0, num_checks = 0, cyc = 0, n;
  shutter_drive #(.TICK_CYC(TK)) dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_END_UP(eu), .I_END_DOWN(ed),
    .O_CONTACT_UP(cu), .O_CONTACT_DOWN(cd), .O_LIMIT_STATUS(lim), .O_IRQ(irq));
  // Motor full travel matches the programmed travel time of 255 ticks
  motor_model #(.RUN(255 * TK)) u_motor (.i_clk(clk), .i_up(cu), .i_down(cd), .o_end_up(eu),
    .o_end_down(ed));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(0, a, 0, r, e);
    chk(r & m, x);
    chk(e, xe);
  endtask
  task automatic wt(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 3000) begin
      @(posedge clk); c++;
    end
    chk(s, v);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(OFF_STATUS, 32'h300, 32'h300, 0);
    rd(OFF_TRAVEL, 32'hFFFF, TRAVEL_RST, 0);
    rd(8'h3C, '1, 0, 1);
    wr(OFF_TRAVEL, 255); wr(OFF_OVERFLOW, 4); wr(OFF_SLAT, 3); wr(OFF_REVERSE, 2);
    wr(OFF_IRQ_MASK, 32'hF);
    wr(OFF_CMD, CMD_DOWN); wt(cd, 1, n); chk(n >= 2 * TK, 1);
    wt(cd, 0, n); chk(n >= 256 * TK && n <= 260 * TK, 1); chk(ed, 1);
    rd(OFF_STATUS, 32'h23FF, 32'h21FF, 0); chk(irq, 1);
    rd(OFF_IRQ_STAT, 3, 3, 0); wr(OFF_IRQ_STAT, 3); repeat (2) @(posedge clk); chk(irq, 0);
    wr(OFF_CMD, CMD_STEP_UP); wt(cu, 1, n); chk(n >= 2 * TK, 1);
    wt(cu, 0, n); chk(n, 3 * TK);
    wr(OFF_CMD, CMD_UP); wt(cu, 1, n); wr(OFF_CMD, CMD_STOP);
    wt(cu, 0, n); chk(n <= TK + 2, 1); chk(cd, 0);
    rd(OFF_STATUS, 32'h2300, 0, 0);
    wr(OFF_SLOT_BASE, 32'h4084); wr(OFF_SCENE, 32'h85); rd(OFF_IRQ_STAT, 4, 0, 0);
    wr(OFF_SCENE, 32'h84); rd(OFF_IRQ_STAT, 4, 4, 0); wr(OFF_IRQ_STAT, 4);
    wr(OFF_SLOT_BASE, 32'h1084); wr(OFF_SCENE, 32'h04); wt(cu, 1, n); wt(cu, 0, n);
    rd(OFF_STATUS, 32'hFF, 32'h10, 0);
    wr(OFF_SAFE_CFG, 32'h1); wr(OFF_SAFE, 1); wt(cd, 1, n); chk(n < 100, 1);
    rd(OFF_IRQ_STAT, 8, 8, 0); wr(OFF_SAFE, 0); wt(cu, 1, n); chk(n < 100, 1);
    wt(cu, 0, n); rd(OFF_STATUS, 32'h3FF, 32'h200, 0);
    wr(OFF_GOTO, 32'h08); wt(cd, 1, n); wt(cd, 0, n);
    rd(OFF_STATUS, 32'h3FF, 32'h08, 0); wr(OFF_IRQ_STAT, 32'hF);
    wr(OFF_CTRL, 0); wr(OFF_CMD, CMD_STEP_DOWN); repeat (40) @(posedge clk);
    chk(cd, 0); rd(OFF_IRQ_STAT, 1, 0, 0);
    wrap_up();
  end
endmodule
